// File: impe_core_model.sv
// Processor core model issuing register reads and writes over APB
`timescale 1ns/1ps
module impe_core_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic pready
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
    end
    // One transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Hold the request until ready is seen at an edge
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines stop showing the old request
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge clk);
    endtask : xfer
    // Service routine end: clear by level, upper bits zero
    task automatic level_clear(input logic [2:0] lv);
        xfer(1'b1, 8'h88, {29'h0000_0000, lv});
    endtask : level_clear
endmodule : impe_core_model

// File: impe_defines.svh
// Constants for the interrupt mask, poll and end-of-service register block
// Functional notes
// - Master mask bits map listed sources
// - Mask register and control masks agree
// - Slave mask resets to 003Dh
// - Slave timer mask bits read control state
// - Peek read equals poll, no side effect
// - Poll read acknowledges and advances
// - Bit 15 flags any pending interrupt
// - Low five bits hold pending type
// - End-of-service write clears in-service flags
// - Master bit 15 picks non-specific clear
// - Slave level field clears that level
// - Slave end-of-service is write-only
// - Vector base holds upper five type bits
// - Vector base other bits read zero
// - Vector offset is type times four
// - Master mask resets to 07FDh
// - In-service set on take, held until cleared
`ifndef IMPE_DEFINES_SVH
`define IMPE_DEFINES_SVH
// Register indices; byte address is four times the index
`define IMPE_IDX_VECBASE 8'h20
`define IMPE_IDX_EOS 8'h22
`define IMPE_IDX_POLL 8'h24
`define IMPE_IDX_PEEK 8'h26
`define IMPE_IDX_MASK 8'h28
`define IMPE_IDX_MODE 8'h30
// Byte addresses on the bus
`define IMPE_ADDR_VECBASE 8'h80
`define IMPE_ADDR_EOS 8'h88
`define IMPE_ADDR_POLL 8'h90
`define IMPE_ADDR_PEEK 8'h98
`define IMPE_ADDR_MASK 8'hA0
`define IMPE_ADDR_MODE 8'hC0
// Reset and writable-bit patterns of the mask register
`define IMPE_MASK_RST_MASTER 16'h07FD
`define IMPE_MASK_RST_SLAVE 16'h003D
`define IMPE_MASK_WR_MASTER 16'h07FD
`define IMPE_MASK_WR_SLAVE 16'h003D
// Field positions
`define IMPE_PEND_FLAG_BIT 15
`define IMPE_ANY_LEVEL_BIT 15
`define IMPE_TYPE_HI 4
`define IMPE_LEVEL_HI 2
`define IMPE_VTU_HI 7
`define IMPE_VTU_LO 3
`define IMPE_VEC_SHIFT 2
`define IMPE_LANE_BITS 8
`define IMPE_MODE_SLAVE_BIT 0
// Zero values
`define IMPE_ZERO16 16'h0000
`define IMPE_ZERO32 32'h0000_0000
`endif

// File: impe_pkg.sv
// Types shared by the interrupt mask, poll and end-of-service block
package impe_pkg;
    // Number of source slots in the mask and in-service layout
    localparam int IMPE_NSRC = 16;
    // Highest-priority pending interrupt offered by the arbiter
    typedef struct packed {
        logic valid;
        logic [3:0] src;
        logic [4:0] ptype;
        logic [2:0] level;
    } impe_pend_type;
    // Acknowledge raised towards the arbiter
    typedef struct packed {
        logic strobe;
        logic [3:0] src;
        logic [4:0] ptype;
    } impe_ack_type;
    // Per-source attributes from the source control registers
    typedef logic [IMPE_NSRC-1:0][2:0] impe_prio_array_type;
    typedef logic [IMPE_NSRC-1:0][4:0] impe_stype_array_type;
    // Bus decode results
    typedef enum {
        IMPE_SEL_NONE,
        IMPE_SEL_VECBASE,
        IMPE_SEL_EOS,
        IMPE_SEL_POLL,
        IMPE_SEL_PEEK,
        IMPE_SEL_MASK,
        IMPE_SEL_MODE
    } impe_sel_type;
endpackage : impe_pkg

// File: impe_regs.sv
// Interrupt mask, poll, end-of-service and vector base registers on APB
`timescale 1ns/1ps
`include "impe_defines.svh"
module impe_regs
    import impe_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and synchronous active-high reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    // Lane 0 covers bits 7 to 0, lane 1 bits 15 to 8
    input wire logic [3:0] pstrb,
    // Always ready; error for an unmapped address
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Mask bit writes from the per-source control registers
    input wire logic [15:0] ctl_mask_wr,
    input wire logic [15:0] ctl_mask_wdata,
    // Current mask towards the control registers and arbiter
    output logic [15:0] source_mask,
    // Highest-priority pending interrupt from the arbiter
    input wire impe_pend_type pend,
    // Hardware acknowledge of the pending interrupt
    input wire logic hw_take,
    // Per-source priority level and interrupt type
    input wire impe_prio_array_type src_prio,
    input wire impe_stype_array_type src_type,
    // Acknowledge caused by a poll read
    output impe_ack_type poll_ack,
    // In-service flags
    output logic [15:0] in_service,
    // Mode seen by the rest of the controller
    output logic slave_mode,
    // Slave-mode interrupt type and vector table offset
    output logic [7:0] vector_type,
    output logic [9:0] vector_offset
);

    // Register state
    // Mask bits, one per source slot, one meaning masked
    logic [15:0] source_mask_reg;
    // Flags of the sources now being serviced
    logic [15:0] in_service_reg;
    // Five upper bits of the slave-mode interrupt type
    logic [4:0] vector_type_upper_reg;
    // One while the controller runs in slave mode
    logic slave_mode_reg;
    // Read word loaded in the setup cycle
    logic [31:0] rdata_reg;
    // Error answer for an unmapped address
    logic err_reg;
    // Setup cycle addressed the acknowledging poll view
    logic poll_hit_reg;
    // Pending state as it stood when the read word was built
    impe_pend_type cap_pend_reg;
    // Acknowledge pulse towards the arbiter
    impe_ack_type ack_reg;
    // Registered interrupt type and table offset
    logic [7:0] vtype_reg;
    logic [9:0] voff_reg;

    // Bus decode and phase strobes
    // Register picked by the current address
    impe_sel_type sel;
    // First cycle of a transfer
    logic setup_phase;
    // Completing cycle of a transfer
    logic access_done;
    // Completing cycle of a write
    logic wr_done;
    // Byte lane enable of bits 7 to 0
    logic lane_lo;
    // Byte lane enable of bits 15 to 8
    logic lane_hi;
    // Low half of the write word; the upper half is ignored
    logic [15:0] wdata16;
    // Mask bits implemented in the current mode
    logic [15:0] wr_keep;

    // End-of-service decode
    // In-service slots whose type equals the written type
    logic [15:0] spec_match;
    // In-service slots whose level equals the written level
    logic [15:0] level_match;
    // Highest-priority in-service slot, one-hot
    logic [15:0] best_onehot;
    // Flags cleared by the current write
    logic [15:0] eos_clear;
    // Flags set by a take or a poll acknowledge
    logic [15:0] take_set;
    // Write asks for a clear of the best in-service slot
    logic any_level_clear_flag;
    // Type field of a specific clear
    logic [4:0] clear_type;
    // Level field of a slave-mode clear
    logic [2:0] clear_level_field;

    // Poll word built from the arbiter's pending state
    // Same word serves the acknowledging and the quiet view
    logic [15:0] poll_word;

    // Zero-wait slave: every access phase completes at once
    // No register needs more than one cycle, so ready never drops
    assign pready = 1'b1;
    // Read word and error come straight from flip-flops
    assign prdata = rdata_reg;
    assign pslverr = err_reg;
    // State seen by the rest of the controller
    assign source_mask = source_mask_reg;
    assign in_service = in_service_reg;
    assign slave_mode = slave_mode_reg;
    // Acknowledge and vector outputs
    assign poll_ack = ack_reg;
    assign vector_type = vtype_reg;
    assign vector_offset = voff_reg;

    // Transfer phases; pready is always high, so access ends it
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable;
    assign wr_done = access_done & pwrite;
    // Only the two low byte lanes reach a 16-bit register
    assign lane_lo = pstrb[0];
    assign lane_hi = pstrb[1];
    // Registers sit in the low half of the word
    assign wdata16 = pwdata[15:0];

    // Address decode to a register select
    // Any other address selects nothing and answers with an error
    always_comb begin
        unique case (paddr)
            `IMPE_ADDR_VECBASE: sel = IMPE_SEL_VECBASE;
            `IMPE_ADDR_EOS: sel = IMPE_SEL_EOS;
            `IMPE_ADDR_POLL: sel = IMPE_SEL_POLL;
            `IMPE_ADDR_PEEK: sel = IMPE_SEL_PEEK;
            `IMPE_ADDR_MASK: sel = IMPE_SEL_MASK;
            `IMPE_ADDR_MODE: sel = IMPE_SEL_MODE;
            // Unmapped offsets
            default: sel = IMPE_SEL_NONE;
        endcase
    end

    // Pending flag in bit 15, type in the low five bits
    // Type is forced to zero while nothing is pending
    always_comb begin
        // Reserved bits 14 to 5 stay zero
        poll_word = `IMPE_ZERO16;
        poll_word[`IMPE_PEND_FLAG_BIT] = pend.valid;
        if (pend.valid) begin
            poll_word[`IMPE_TYPE_HI:0] = pend.ptype;
        end
    end

    // Mask bits software may change in the current mode
    // Bits outside this pattern read zero and ignore writes
    assign wr_keep = slave_mode_reg ? `IMPE_MASK_WR_SLAVE
                                    : `IMPE_MASK_WR_MASTER;

    // Read data and error are prepared in the setup cycle
    // so the word already stands when the access phase samples it
    always_ff @(posedge clk) begin
        if (rst) begin
            // Empty word, no error
            rdata_reg <= `IMPE_ZERO32;
            err_reg <= 1'b0;
        end else if (setup_phase) begin
            // New transfer: clear first, then fill the selected field
            rdata_reg <= `IMPE_ZERO32;
            err_reg <= (sel == IMPE_SEL_NONE);
            // Only reads load a register's content
            if (!pwrite) begin
                unique case (sel)
                    // Upper type bits only; the rest reads zero
                    IMPE_SEL_VECBASE: begin
                        rdata_reg[`IMPE_VTU_HI:`IMPE_VTU_LO] <=
                            vector_type_upper_reg;
                    end
                    // Write-only: reads as zero
                    IMPE_SEL_EOS: rdata_reg <= `IMPE_ZERO32;
                    // Both poll views return the same word
                    IMPE_SEL_POLL: rdata_reg[15:0] <= poll_word;
                    IMPE_SEL_PEEK: rdata_reg[15:0] <= poll_word;
                    // One storage shared with the control registers
                    IMPE_SEL_MASK: begin
                        rdata_reg[15:0] <= source_mask_reg & wr_keep;
                    end
                    // Mode flag in bit 0, the rest reads zero
                    IMPE_SEL_MODE: begin
                        rdata_reg[`IMPE_MODE_SLAVE_BIT] <= slave_mode_reg;
                    end
                    // Unmapped: zero word with the error set
                    IMPE_SEL_NONE: rdata_reg <= `IMPE_ZERO32;
                endcase
            end
        end
    end

    // Pending state captured with the read word, so the ack matches it
    // The arbiter may move on between setup and access
    always_ff @(posedge clk) begin
        if (rst) begin
            // Nothing captured after reset
            cap_pend_reg <= '0;
            poll_hit_reg <= 1'b0;
        end else if (setup_phase) begin
            cap_pend_reg <= pend;
            // Only a read of the poll view may acknowledge
            poll_hit_reg <= ~pwrite & (sel == IMPE_SEL_POLL);
        end
    end

    // Poll read completion acknowledges what it reported
    // One-cycle pulse in the cycle after the access completes
    always_ff @(posedge clk) begin
        if (rst) begin
            // No acknowledge during reset
            ack_reg <= '0;
        end else begin
            // Pulse, source and type are renewed every cycle
            // Nothing pending means no acknowledge at all
            ack_reg.strobe <= access_done & ~pwrite & poll_hit_reg &
                              cap_pend_reg.valid;
            // Source and type of the reported interrupt
            ack_reg.src <= cap_pend_reg.src;
            ack_reg.ptype <= cap_pend_reg.ptype;
        end
    end

    // Mode register; a change reloads that mode's mask reset value
    // Bit 0 of the mode write selects slave mode
    always_ff @(posedge clk) begin
        if (rst) begin
            // Master mode after reset
            slave_mode_reg <= 1'b0;
        end else if (wr_done && sel == IMPE_SEL_MODE && lane_lo) begin
            slave_mode_reg <= wdata16[`IMPE_MODE_SLAVE_BIT];
        end
    end

    // Source mask shared with the per-source control registers
    // One copy only, so the mask view and the control view agree
    always_ff @(posedge clk) begin
        if (rst) begin
            // Reset masks every master source
            source_mask_reg <= `IMPE_MASK_RST_MASTER;
        // A mode change overrides both kinds of write
        end else if (wr_done && sel == IMPE_SEL_MODE && lane_lo &&
                     wdata16[`IMPE_MODE_SLAVE_BIT] != slave_mode_reg) begin
            // Entering a mode restarts with all its sources masked
            source_mask_reg <= wdata16[`IMPE_MODE_SLAVE_BIT]
                               ? `IMPE_MASK_RST_SLAVE
                               : `IMPE_MASK_RST_MASTER;
        end else begin
            // Bit by bit, so a control write and a bus write can mix
            for (int b = 0; b < IMPE_NSRC; b++) begin
                // A control register write of the same bit takes over
                if (ctl_mask_wr[b]) begin
                    source_mask_reg[b] <= ctl_mask_wdata[b] & wr_keep[b];
                end else if (wr_done && sel == IMPE_SEL_MASK &&
                             (b < `IMPE_LANE_BITS ? lane_lo : lane_hi)) begin
                    // One masks, zero enables; unused bits stay zero
                    source_mask_reg[b] <= wdata16[b] & wr_keep[b];
                end
            end
        end
    end

    // Vector type base: five upper type bits
    // Low lane only: bits 7 to 3 of the write word
    always_ff @(posedge clk) begin
        if (rst) begin
            // Left undefined by the device; cleared here
            vector_type_upper_reg <= 5'h00;
        end else if (wr_done && sel == IMPE_SEL_VECBASE && lane_lo) begin
            vector_type_upper_reg <=
                wdata16[`IMPE_VTU_HI:`IMPE_VTU_LO];
        end
    end

    // Slave type joins base with the pending level; offset is type x4
    // Follows the pending level whether or not it is valid
    always_ff @(posedge clk) begin
        if (rst) begin
            // Zero type and offset after reset
            vtype_reg <= 8'h00;
            voff_reg <= 10'h000;
        end else begin
            // Low three type bits come from the priority level
            vtype_reg <= {vector_type_upper_reg, pend.level};
            // Offset is the type shifted left by two
            voff_reg <= {vector_type_upper_reg, pend.level,
                         2'h0};
        end
    end

    // End-of-service write fields
    // Decoded every cycle, used only in a completing write
    assign any_level_clear_flag = wdata16[`IMPE_ANY_LEVEL_BIT];
    assign clear_type = wdata16[`IMPE_TYPE_HI:0];
    // Slave clears name a level in bits 2 to 0
    assign clear_level_field = wdata16[`IMPE_LEVEL_HI:0];

    // Per-source match of the written type or level
    // Only slots now in service can match
    genvar gi;
    generate
        for (gi = 0; gi < IMPE_NSRC; gi++) begin : g_src
            assign spec_match[gi] = in_service_reg[gi] &
                                    (src_type[gi] == clear_type);
            assign level_match[gi] = in_service_reg[gi] &
                                     (src_prio[gi] == clear_level_field);
            // Set on a hardware take or a poll acknowledge
            assign take_set[gi] =
                (hw_take & pend.valid & (pend.src == gi)) |
                (ack_reg.strobe & (ack_reg.src == gi));
        end
    endgenerate

    // In-service source of numerically lowest level, lowest slot on tie
    // Lower level number means higher priority
    always_comb begin
        // Some slot already chosen
        logic found;
        // Level of the slot chosen so far
        logic [2:0] best_lvl;
        found = 1'b0;
        best_lvl = 3'h7;
        best_onehot = `IMPE_ZERO16;
        for (int b = 0; b < IMPE_NSRC; b++) begin
            if (in_service_reg[b] && (!found || src_prio[b] < best_lvl)) begin
                found = 1'b1;
                best_lvl = src_prio[b];
                best_onehot = 16'h0001 << b;
            end
        end
    end

    // Which in-service flags an end-of-service write clears
    // Nothing is cleared outside a completing write with lane 0
    always_comb begin
        eos_clear = `IMPE_ZERO16;
        if (wr_done && sel == IMPE_SEL_EOS && lane_lo) begin
            // Slave mode clears by level, master by type or, with bit 15, by priority
            if (slave_mode_reg) begin
                // Level field names the flag to clear
                eos_clear = level_match;
            // Non-specific clear needs the high lane for bit 15
            end else if (lane_hi && any_level_clear_flag) begin
                eos_clear = best_onehot;
            end else begin
                // Specific clear by interrupt type
                eos_clear = spec_match;
            end
        end
    end

    // In-service flags; a set in the same cycle beats a clear
    // so a source taken as its old flag is cleared stays in service
    always_ff @(posedge clk) begin
        if (rst) begin
            // Nothing in service after reset
            in_service_reg <= `IMPE_ZERO16;
        end else begin
            in_service_reg <= (in_service_reg & ~eos_clear) |
                              take_set;
        end
    end

endmodule : impe_regs

// File: impe_regs_monitor.sv
// Checker for the mask, poll and end-of-service register block
`timescale 1ns/1ps
module impe_regs_monitor
    import impe_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic [15:0] ctl_mask_wr,
    input wire logic [15:0] ctl_mask_wdata,
    input wire logic [15:0] source_mask,
    input wire impe_pend_type pend,
    input wire logic hw_take,
    input wire impe_ack_type poll_ack,
    input wire logic [15:0] in_service,
    input wire logic slave_mode,
    input wire logic [7:0] vector_type,
    input wire logic [9:0] vector_offset
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);
    // Read access phase on the bus
    logic rd_acc;
    assign rd_acc = psel && penable && !pwrite;
    a_mask_reset: assert property (
        $past(rst) |-> source_mask == 16'h07FD
    ) else $error("mask not at its reset value");
    a_poll_ack: assert property (
        rd_acc && paddr == 8'h90 |=> poll_ack.strobe == $past(pend.valid, 2)
    ) else $error("poll read acknowledge wrong");
    a_ack_pulse: assert property (
        poll_ack.strobe |=> !poll_ack.strobe
    ) else $error("acknowledge longer than one cycle");
    a_peek_quiet: assert property (
        rd_acc && paddr == 8'h98 |=> !poll_ack.strobe
    ) else $error("peek read acknowledged");
    a_ack_busy: assert property (
        poll_ack.strobe |=> in_service[$past(poll_ack.src)]
    ) else $error("poll acknowledge left flag clear");
    a_take_busy: assert property (
        hw_take && pend.valid |=> in_service[$past(pend.src)]
    ) else $error("hardware take left flag clear");
    a_poll_word: assert property (
        rd_acc && (paddr == 8'h90 || paddr == 8'h98) |-> prdata[15:0] ==
        ($past(pend.valid) ? {1'b1, 10'h000, $past(pend.ptype)} : 16'h0000)
    ) else $error("poll word wrong");
    a_vec_offset: assert property (
        vector_offset == {vector_type, 2'b00}
    ) else $error("vector offset not type times four");
    a_vec_level: assert property (
        !$past(rst) |-> vector_type[2:0] == $past(pend.level)
    ) else $error("vector type low bits wrong");
    a_master_bits: assert property (
        !slave_mode |-> (source_mask & 16'hF802) == 16'h0000
    ) else $error("reserved master mask bit set");
    a_slave_bits: assert property (
        slave_mode |-> (source_mask & 16'hFFC2) == 16'h0000
    ) else $error("reserved slave mask bit set");
    a_ctl_mask: assert property (
        |ctl_mask_wr && !(psel && penable && pwrite && paddr == 8'hC0) |=>
        ((source_mask ^ $past(ctl_mask_wdata)) & $past(ctl_mask_wr)
        & (slave_mode ? 16'h003D : 16'h07FD)) == 16'h0000
    ) else $error("control mask write lost");
    // Main scenarios reached
    c_poll: cover property (poll_ack.strobe);
    c_take: cover property (hw_take);
    c_slave: cover property (slave_mode);
endmodule : impe_regs_monitor

bind impe_regs impe_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk, .rst,
    .psel, .penable, .pwrite, .paddr, .prdata, .ctl_mask_wr,
    .ctl_mask_wdata, .source_mask, .pend, .hw_take, .poll_ack,
    .in_service, .slave_mode, .vector_type, .vector_offset);

// File: interrupt_mask_poll_eoi_regs_tb.sv
// Self-checking bench for the mask, poll and end-of-service registers
`timescale 1ns/1ps
module interrupt_mask_poll_eoi_regs_tb
    import impe_pkg::*;
;
    logic clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [15:0] ctl_mask_wr;
    logic [15:0] ctl_mask_wdata;
    logic [15:0] source_mask;
    impe_pend_type pend;
    logic hw_take;
    impe_prio_array_type src_prio;
    impe_stype_array_type src_type;
    impe_ack_type poll_ack;
    logic [15:0] in_service;
    logic slave_mode;
    logic [7:0] vector_type;
    logic [9:0] vector_offset;
    logic [32:0] exp_q[$]; // Expected {error, read data}
    logic [31:0] seed;
    int error_cnt;
    int compares;
    int cycles;
    impe_regs uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .pready, .prdata, .pslverr, .ctl_mask_wr, .ctl_mask_wdata,
        .source_mask, .pend, .hw_take, .src_prio, .src_type, .poll_ack,
        .in_service, .slave_mode, .vector_type, .vector_offset);
    impe_core_model core (.clk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .pready);
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Random source
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    // Final report and end of run
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    // Compare one value with its expectation
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // Read with its expected answer queued
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        core.xfer(1'b0, a, 32'h0000_0000);
    endtask : rd
    // Write of a 16-bit register
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        core.xfer(1'b1, a, {16'h0000, d});
    endtask : wr
    // Hardware acknowledge of one slot
    task automatic take(input logic [3:0] s);
        pend.valid <= 1'b1;
        pend.src <= s;
        hw_take <= 1'b1;
        @(posedge clk);
        hw_take <= 1'b0;
        pend.valid <= 1'b0;
        @(posedge clk);
    endtask : take
    // Look at the in-service flags once settled
    task automatic see(input logic [15:0] e);
        @(negedge clk);
        check({17'h0_0000, in_service}, {17'h0_0000, e});
        @(posedge clk);
    endtask : see
    // Watcher: every completed read against the oldest expectation
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        ctl_mask_wr = 16'h0000;
        ctl_mask_wdata = 16'h0000;
        pend = '0;
        hw_take = 1'b0;
        seed = 32'h5965;
        for (int i = 0; i < IMPE_NSRC; i++) begin
            src_prio[i] = 3'(7 - i);
            src_type[i] = 5'(i + 8);
        end
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'hA0, 33'h0_0000_07FD);
        repeat (4) begin
            seed = xs(seed);
            wr(8'hA0, seed[15:0]);
            rd(8'hA0, {17'h0_0000, seed[15:0] & 16'h07FD});
        end
        wr(8'hA0, 16'hFFFF);
        ctl_mask_wr <= 16'h0200;
        @(posedge clk);
        ctl_mask_wr <= 16'h0000;
        @(posedge clk);
        rd(8'hA0, 33'h0_0000_05FD);
        // Pending source 3 seen twice by peek, then taken by poll
        pend <= {1'b1, 4'h3, seed[20:16], 3'h6};
        @(posedge clk);
        repeat (2) rd(8'h98, {18'h0_0001, 10'h000, seed[20:16]});
        see(16'h0000);
        rd(8'h90, {18'h0_0001, 10'h000, seed[20:16]});
        see(16'h0008);
        pend <= '0;
        @(posedge clk);
        rd(8'h90, 33'h0_0000_0000);
        see(16'h0008);
        wr(8'h88, 16'h000B);
        see(16'h0000);
        take(4'h2);
        take(4'h5);
        wr(8'h88, 16'h8000);
        see(16'h0004);
        rd(8'h88, 33'h0_0000_0000);
        rd(8'h84, 33'h1_0000_0000);
        // Slave mode
        wr(8'hC0, 16'h0001);
        rd(8'hA0, 33'h0_0000_003D);
        ctl_mask_wr <= 16'h0020;
        @(posedge clk);
        ctl_mask_wr <= 16'h0000;
        @(posedge clk);
        rd(8'hA0, 33'h0_0000_001D);
        pend <= {1'b0, 4'h0, 5'h00, 3'h5};
        wr(8'h80, 16'hFFFF);
        rd(8'h80, 33'h0_0000_00F8);
        @(negedge clk);
        check({25'h000_0000, vector_type}, 33'h0_0000_00FD);
        check({23'h00_0000, vector_offset}, 33'h0_0000_03F4);
        @(posedge clk);
        take(4'h5);
        core.level_clear(3'h2);
        see(16'h0004);
        print_verdict();
    end
endmodule : interrupt_mask_poll_eoi_regs_tb
